//--- design/aid_pkg.sv
package aid_pkg;

	// **********************************************
	// Timing
	// **********************************************
	localparam int unsigned CYC_CLKS   = 4; // core clocks per instruction cycle
	localparam int unsigned CYC_ONE    = 1;
	localparam int unsigned CYC_TWO    = 2;
	localparam int unsigned CYC_DP_INC = 3;
	localparam int unsigned CYC_MULDIV = 5;

	// **********************************************
	// Opcode groups (high nibble) and modes (low nibble)
	// **********************************************
	localparam logic [3:0] GRP_INC        = 4'h0;
	localparam logic [3:0] GRP_DEC        = 4'h1;
	localparam logic [3:0] GRP_ADD        = 4'h2;
	localparam logic [3:0] GRP_ADD_CARRY  = 4'h3;
	localparam logic [3:0] GRP_AND        = 4'h5;
	localparam logic [3:0] GRP_SUB_BORROW = 4'h9;
	localparam logic [3:0] MODE_AIM = 4'h4; // accumulator or immediate
	localparam logic [3:0] MODE_DIR = 4'h5;
	localparam logic [7:0] OP_INC_DP = 8'hA3;
	localparam logic [7:0] OP_MUL    = 8'hA4;
	localparam logic [7:0] OP_DIV    = 8'h84;
	localparam logic [7:0] OP_DA     = 8'hD4;

	// **********************************************
	// Special function addresses and flag positions
	// **********************************************
	localparam logic [7:0] SFR_ACC = 8'hE0;
	localparam logic [7:0] SFR_B   = 8'hF0;
	localparam logic [7:0] SFR_PSW = 8'hD0;
	localparam logic [7:0] SFR_DPL = 8'h82;
	localparam logic [7:0] SFR_DPH = 8'h83;
	localparam int unsigned PSW_CY  = 7;
	localparam int unsigned PSW_AC  = 6;
	localparam int unsigned PSW_RS1 = 4;
	localparam int unsigned PSW_RS0 = 3;
	localparam int unsigned PSW_OV  = 2;
	localparam int unsigned PSW_P   = 0;

	// **********************************************
	// Reset values
	// **********************************************
	localparam logic [15:0] RST_PC   = 16'h0000;
	localparam logic [7:0]  RST_BYTE = 8'h00;

	typedef struct packed {
		logic [15:0] data_pointer;
		logic [7:0]  psw;
		logic [7:0]  b;
		logic [7:0]  acc;
	} aid_regs_s;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} aid_load_s;

	typedef enum logic [2:0] {ST_FETCH, ST_OPERAND, ST_ADDR, ST_EXEC, ST_WAIT} aid_state_e;

endpackage : aid_pkg

//--- design/aid_dmem.sv
`timescale 1ns/1ns
module aid_dmem #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 256,
	parameter int unsigned AW    = 8
) (
	input  wire logic             core_clk, // core clock
	input  wire logic             clk_en,   // freezes memory when low
	input  wire logic             rd_en,    // read strobe
	input  wire logic [AW-1:0]    rd_addr,  // read address
	output logic      [WIDTH-1:0] rd_data,  // registered read data
	input  wire logic             wr_en,    // write strobe
	input  wire logic [AW-1:0]    wr_addr,  // write address
	input  wire logic [WIDTH-1:0] wr_data   // write data
);

	logic [WIDTH-1:0] mem [DEPTH];

	// No reset: contents are whatever was last written
	always_ff @(posedge core_clk)
	begin
		if (clk_en)
		begin
			if (wr_en)
				mem[wr_addr] <= wr_data;
			if (rd_en)
				rd_data <= mem[rd_addr];
		end
	end

endmodule : aid_dmem

//--- design/aid_core.sv
`timescale 1ns/1ns
module aid_core
	import aid_pkg::*;
(
	input  wire logic        core_clk,       // core clock, 50 MHz
	input  wire logic        reset_n,        // async reset, active low
	input  wire logic        clk_en,         // freezes all state when low
	output logic      [15:0] prog_addr,      // program memory address
	input  wire logic [7:0]  prog_data,      // program byte at prog_addr
	input  aid_load_s        mem_load,       // data memory preload
	output aid_regs_s        core_regs,      // accumulator, B, flags, data pointer
	output logic             instr_done,     // pulse after each instruction
	output logic             opcode_unknown  // pulse: last opcode not handled
);

	// **********************************************
	// State
	// **********************************************
	aid_state_e  state, next_state;
	logic [15:0] pc, next_pc;
	logic [7:0]  opcode, next_opcode;
	logic [7:0]  operand, next_operand;
	logic [7:0]  tgt_addr, next_tgt;
	logic [4:0]  cyc_cnt, next_cnt;
	aid_regs_s   regs, next_regs;
	logic        next_done, next_unknown;

	logic        rd_en, wr_en, core_wr;
	logic [7:0]  rd_addr, wr_addr, wr_data, core_wr_addr, core_wr_data, mem_rdata;

	// **********************************************
	// Decode
	// **********************************************
	logic [3:0] grp, mode;
	logic       is_wreg, is_ind, is_dir, is_aim, arith, incdec, is_and, supported, two_byte;
	logic [2:0] inst_cyc;
	logic [4:0] last_cnt;
	logic [1:0] bank;
	logic [7:0] ptr_addr, eff_addr, opnd, sfr_rd;

	assign grp    = opcode[7:4];
	assign mode   = opcode[3:0];
	assign is_wreg = opcode[3];
	assign is_ind = (mode[3:1] == 3'b011);
	assign is_dir = (mode == MODE_DIR);
	assign is_aim = (mode == MODE_AIM);
	assign arith  = (grp == GRP_ADD) || (grp == GRP_ADD_CARRY) || (grp == GRP_SUB_BORROW);
	assign incdec = (grp == GRP_INC) || (grp == GRP_DEC);
	assign is_and = (grp == GRP_AND) && is_wreg;
	assign supported = ((arith || incdec) && mode >= MODE_AIM) || is_and
		|| opcode == OP_INC_DP || opcode == OP_MUL || opcode == OP_DIV || opcode == OP_DA;
	assign two_byte = (arith && (is_aim || is_dir)) || (incdec && is_dir);

	always_comb
	begin
		if (opcode == OP_MUL || opcode == OP_DIV)
			inst_cyc = 3'(CYC_MULDIV);
		else if (opcode == OP_INC_DP)
			inst_cyc = 3'(CYC_DP_INC);
		else if (two_byte)
			inst_cyc = 3'(CYC_TWO);
		else
			inst_cyc = 3'(CYC_ONE);
	end
	assign last_cnt = 5'(inst_cyc * CYC_CLKS - 1);

	assign bank     = regs.psw[PSW_RS1:PSW_RS0];
	assign ptr_addr = {3'b000, bank, is_ind ? {2'b00, opcode[0]} : opcode[2:0]};
	assign eff_addr = is_ind ? mem_rdata : (is_dir ? operand : ptr_addr);

	always_comb
	begin
		case (tgt_addr)
			SFR_ACC: sfr_rd = regs.acc;
			SFR_B:   sfr_rd = regs.b;
			SFR_PSW: sfr_rd = regs.psw;
			SFR_DPL: sfr_rd = regs.data_pointer[7:0];
			SFR_DPH: sfr_rd = regs.data_pointer[15:8];
			default: sfr_rd = RST_BYTE;
		endcase
	end

	assign opnd = (arith && is_aim) ? operand : ((is_dir && tgt_addr[7]) ? sfr_rd : mem_rdata);

	// **********************************************
	// Arithmetic
	// **********************************************
	logic       cin, is_sub, add_ov, sub_ov, da_fix;
	logic [8:0] add9, sub9, da_lo, da_res;
	logic [4:0] addh, subh;
	logic [7:0] idv, id_res, div_b;
	logic [15:0] prod;

	// carry in for add-with-carry and subtract-with-borrow
	assign cin    = (grp == GRP_ADD_CARRY || grp == GRP_SUB_BORROW) ? regs.psw[PSW_CY] : 1'b0;
	assign is_sub = (grp == GRP_SUB_BORROW);
	assign add9   = {1'b0, regs.acc} + {1'b0, opnd} + {8'h00, cin};
	assign addh   = {1'b0, regs.acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
	assign sub9   = {1'b0, regs.acc} - {1'b0, opnd} - {8'h00, cin};
	assign subh   = {1'b0, regs.acc[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cin};
	assign add_ov = (regs.acc[7] == opnd[7]) && (add9[7] != regs.acc[7]);
	assign sub_ov = (regs.acc[7] != opnd[7]) && (sub9[7] != regs.acc[7]);
	assign idv    = is_aim ? regs.acc : opnd;
	assign id_res = (grp == GRP_INC) ? 8'(idv + 8'h01) : 8'(idv - 8'h01);
	assign prod   = 16'(regs.acc) * 16'(regs.b);
	assign div_b  = (regs.b == RST_BYTE) ? 8'h01 : regs.b;
	// decimal adjust, low then high digit
	assign da_lo  = (regs.acc[3:0] > 4'h9 || regs.psw[PSW_AC]) ? {1'b0, regs.acc} + 9'h006 : {1'b0, regs.acc};
	assign da_fix = (da_lo[7:4] > 4'h9) || regs.psw[PSW_CY] || da_lo[8];
	assign da_res = da_fix ? {1'b0, da_lo[7:0]} + 9'h060 : {1'b0, da_lo[7:0]};

	// **********************************************
	// Sequencer and execute
	// **********************************************
	always_comb
	begin
		next_state   = state;
		next_pc      = pc;
		next_opcode  = opcode;
		next_operand = operand;
		next_tgt     = tgt_addr;
		next_cnt     = 5'(cyc_cnt + 5'd1);
		next_regs    = regs;
		next_done    = 1'b0;
		next_unknown = 1'b0;
		rd_en        = 1'b0;
		rd_addr      = ptr_addr;
		core_wr      = 1'b0;
		core_wr_addr = tgt_addr;
		core_wr_data = id_res;
		case (state)
			ST_FETCH:
			begin
				next_opcode = prog_data;
				next_pc     = 16'(pc + 16'd1);
				next_cnt    = 5'd1;
				next_state  = ST_OPERAND;
			end
			ST_OPERAND:
			begin
				rd_en = 1'b1;
				if (two_byte)
				begin
					next_operand = prog_data;
					next_pc      = 16'(pc + 16'd1);
				end
				next_state = ST_ADDR;
			end
			ST_ADDR:
			begin
				// indirect address taken from pointer register
				rd_en      = is_wreg || is_ind || (is_dir && !operand[7]);
				rd_addr    = eff_addr;
				next_tgt   = eff_addr;
				next_state = ST_EXEC;
			end
			ST_EXEC:
			begin
				next_state   = (cyc_cnt == last_cnt) ? ST_FETCH : ST_WAIT;
				next_done    = (cyc_cnt == last_cnt);
				next_unknown = (cyc_cnt == last_cnt) && !supported;
				// Low modes of the arithmetic groups are not handled and must stay no-ops
				if (arith && mode >= MODE_AIM)
				begin
					next_regs.acc          = is_sub ? sub9[7:0] : add9[7:0];
					next_regs.psw[PSW_CY]  = is_sub ? sub9[8] : add9[8];
					next_regs.psw[PSW_AC]  = is_sub ? subh[4] : addh[4];
					next_regs.psw[PSW_OV]  = is_sub ? sub_ov : add_ov;
				end
				else if (is_and)
				begin
					next_regs.acc = regs.acc & opnd;
				end
				else if (incdec && mode >= MODE_AIM)
				begin
					if (is_aim)
						next_regs.acc = id_res;
					else if (is_dir && tgt_addr[7])
					begin
						case (tgt_addr)
							SFR_ACC: next_regs.acc = id_res;
							SFR_B:   next_regs.b = id_res;
							SFR_PSW: next_regs.psw = id_res;
							SFR_DPL: next_regs.data_pointer[7:0] = id_res;
							SFR_DPH: next_regs.data_pointer[15:8] = id_res;
							default: next_regs.b = regs.b;
						endcase
					end
					else
					begin
						core_wr = 1'b1;
					end
				end
				else
				begin
					case (opcode)
						OP_INC_DP: next_regs.data_pointer = 16'(regs.data_pointer + 16'd1);
						OP_MUL:
						begin
							next_regs.acc         = prod[7:0];
							next_regs.b           = prod[15:8];
							next_regs.psw[PSW_CY] = 1'b0;
							next_regs.psw[PSW_OV] = (prod[15:8] != RST_BYTE);
						end
						OP_DIV:
						begin
							// divide by zero keeps A and B, sets overflow
							next_regs.psw[PSW_CY] = 1'b0;
							next_regs.psw[PSW_OV] = (regs.b == RST_BYTE);
							if (regs.b != RST_BYTE)
							begin
								next_regs.acc = regs.acc / div_b;
								next_regs.b   = regs.acc % div_b;
							end
						end
						OP_DA:
						begin
							next_regs.acc         = da_res[7:0];
							next_regs.psw[PSW_CY] = da_fix;
						end
						default: next_regs.acc = regs.acc;
					endcase
				end
			end
			ST_WAIT:
			begin
				if (cyc_cnt == last_cnt)
				begin
					next_state   = ST_FETCH;
					next_done    = 1'b1;
					next_unknown = !supported;
				end
			end
			default: next_state = ST_FETCH;
		endcase
		// Parity always follows the accumulator
		next_regs.psw[PSW_P] = ^next_regs.acc;
	end

	// Preload only gets the port when the core is not writing
	assign wr_en   = core_wr || mem_load.en;
	assign wr_addr = core_wr ? core_wr_addr : mem_load.addr;
	assign wr_data = core_wr ? core_wr_data : mem_load.data;

	aid_dmem #(
		.WIDTH (8),
		.DEPTH (256),
		.AW    (8)
	) u_dmem (
		.core_clk (core_clk),
		.clk_en   (clk_en),
		.rd_en    (rd_en),
		.rd_addr  (rd_addr),
		.rd_data  (mem_rdata),
		.wr_en    (wr_en),
		.wr_addr  (wr_addr),
		.wr_data  (wr_data)
	);

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state          <= ST_FETCH;
			pc             <= RST_PC;
			opcode         <= RST_BYTE;
			operand        <= RST_BYTE;
			tgt_addr       <= RST_BYTE;
			cyc_cnt        <= 5'd0;
			regs           <= '0;
			instr_done     <= 1'b0;
			opcode_unknown <= 1'b0;
		end
		else if (clk_en)
		begin
			state          <= next_state;
			pc             <= next_pc;
			opcode         <= next_opcode;
			operand        <= next_operand;
			tgt_addr       <= next_tgt;
			cyc_cnt        <= next_cnt;
			regs           <= next_regs;
			instr_done     <= next_done;
			opcode_unknown <= next_unknown;
		end
	end

	assign prog_addr = pc;
	assign core_regs = regs;

	// **********************************************
	// Checks
	// **********************************************
	logic        exec_fire, retire;
	logic [15:0] pc_start;

	assign exec_fire = (state == ST_EXEC) && clk_en;
	assign retire    = clk_en && (state == ST_EXEC || state == ST_WAIT) && next_state == ST_FETCH;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			pc_start <= RST_PC;
		else if (clk_en && state == ST_FETCH)
			pc_start <= pc;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	a_add_reg_acc : assert property (
		exec_fire && opcode[7:3] == 5'b00101 |=> regs.acc == 8'($past(regs.acc) + $past(opnd)))
		else $error("add register result wrong");
	a_two_byte_len : assert property (
		retire && (opcode == 8'h25 || opcode == 8'h24) |-> cyc_cnt == 5'd7 && pc == 16'(pc_start + 16'd2))
		else $error("two-byte add length or timing wrong");
	a_one_cycle_len : assert property (
		retire && opcode[7:1] == 7'b0010011 |-> cyc_cnt == 5'd3 && pc == 16'(pc_start + 16'd1))
		else $error("indirect add length or timing wrong");
	a_add_carry_in : assert property (
		exec_fire && opcode[7:3] == 5'b00111
		|=> regs.acc == 8'($past(regs.acc) + $past(opnd) + {7'd0, $past(regs.psw[PSW_CY])}))
		else $error("add with carry result wrong");
	a_sub_borrow : assert property (
		exec_fire && opcode[7:3] == 5'b10011
		|=> regs.acc == 8'($past(regs.acc) - $past(opnd) - {7'd0, $past(regs.psw[PSW_CY])}))
		else $error("subtract with borrow result wrong");
	a_dp_carry : assert property (
		exec_fire && opcode == OP_INC_DP |=> regs.data_pointer == 16'($past(regs.data_pointer) + 16'd1))
		else $error("data pointer increment wrong");
	a_mul_split : assert property (
		exec_fire && opcode == OP_MUL |=> {regs.b, regs.acc} == 16'($past(prod)) ##1 $stable(regs.acc) [*3])
		else $error("multiply result or hold wrong");
	a_and_reg : assert property (
		exec_fire && is_and |=> regs.acc == ($past(regs.acc) & $past(opnd)))
		else $error("and result wrong");
	a_incdec_flags : assert property (
		exec_fire && incdec && !is_dir |=> regs.psw[7:1] == $past(regs.psw[7:1]))
		else $error("increment changed flags");

	c_add_direct : cover property (retire && opcode == 8'h25);
	c_div_zero   : cover property (exec_fire && opcode == OP_DIV && regs.b == RST_BYTE);
	c_da_carry   : cover property (exec_fire && opcode == OP_DA && da_fix);
	c_inc_ind    : cover property (exec_fire && opcode == 8'h06);

endmodule : aid_core

//--- tb/aid_prog_model.sv
`timescale 1ns/1ns
module aid_prog_model
	import aid_pkg::*;
(
	input  wire logic [15:0] prog_addr, // address from the core
	output logic      [7:0]  prog_data  // byte at that address
);
	logic [7:0] rom [0:255];

	// ****************************************
	// Asynchronous read
	// ****************************************
	// Outside the loaded page a reserved opcode comes back, so a stray fetch is seen, not hidden as zero
	assign prog_data = (prog_addr[15:8] == 8'h00) ? rom[prog_addr[7:0]] : 8'hA5;
endmodule : aid_prog_model

//--- tb/arith_instruction_decode_tb.sv
`timescale 1ns/1ns
module arith_instruction_decode_tb;
	import aid_pkg::*;

	typedef struct {
		logic [7:0]  op;
		logic [7:0]  arg;
		int          len;
		int          clks;
		logic [7:0]  acc;
		logic [7:0]  fl;
		logic [7:0]  b;
		logic [15:0] dp;
		logic        unk;
	} aid_step_s;

	localparam int LIMIT = 20000;
	localparam logic [7:0] PRE_A [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h30, 8'h31, 8'h40, 8'h41};
	localparam logic [7:0] PRE_D [8] = '{8'h30, 8'h31, 8'h55, 8'h00, 8'h12, 8'hF0, 8'h77, 8'h00};

	logic        core_clk = 1'b0;
	logic        reset_n  = 1'b0;
	logic        clk_en   = 1'b1;
	logic        gap      = 1'b0;
	logic [15:0] prog_addr;
	logic [7:0]  prog_data;
	aid_load_s   mem_load = '0;
	aid_regs_s   core_regs;
	logic        instr_done;
	logic        opcode_unknown;
	int          mismatches  = 0;
	int          checks_done = 0;
	int          cycles      = 0;
	aid_step_s   steps [$];

	aid_core u_aid_core (
		.core_clk       (core_clk),
		.reset_n        (reset_n),
		.clk_en         (clk_en),
		.prog_addr      (prog_addr),
		.prog_data      (prog_data),
		.mem_load       (mem_load),
		.core_regs      (core_regs),
		.instr_done     (instr_done),
		.opcode_unknown (opcode_unknown)
	);

	aid_prog_model u_aid_prog_model (
		.prog_addr (prog_addr),
		.prog_data (prog_data)
	);

	always #10 core_clk = ~core_clk;

	// ****************************************
	// Reporting
	// ****************************************
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim

	task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			mismatches++;
			$display("MISMATCH t=%0t run did not finish", $time);
			end_sim();
		end
	end

	// ****************************************
	// Step table and runner
	// ****************************************
	function automatic void st(input logic [7:0] op, input logic [7:0] arg, input int len, input int clks,
		input logic [7:0] acc, input logic [7:0] fl, input logic [7:0] b = 8'h00,
		input logic [15:0] dp = 16'h0000, input logic unk = 1'b0);
		steps.push_back('{op, arg, len, clks, acc, fl, b, dp, unk});
	endfunction : st

	// Reset in mid-program, load the program, preload data memory, then step through it
	task automatic run(input string name);
		int        a;
		int        n;
		logic      en_at;
		aid_regs_s e;
		logic [15:0] pc_exp;
		@(posedge core_clk);
		#1 reset_n = 1'b0;
		clk_en = 1'b1;
		for (a = 0; a < 256; a++)
			u_aid_prog_model.rom[a] = 8'hA5;
		a = 0;
		foreach (steps[i])
		begin
			u_aid_prog_model.rom[a] = steps[i].op;
			if (steps[i].len == 2)
				u_aid_prog_model.rom[a + 1] = steps[i].arg;
			a += steps[i].len;
		end
		for (int i = 0; i < 8; i++)
		begin
			mem_load = '{en: 1'b1, addr: PRE_A[i], data: PRE_D[i]};
			@(posedge core_clk);
			#1;
		end
		mem_load.en = 1'b0;
		repeat (2) @(posedge core_clk);
		#1 check(core_regs, '0, "reset regs");
		check({24'h0, prog_addr}, '0, "reset pc");
		reset_n = 1'b1;
		pc_exp = 16'h0000;
		foreach (steps[i])
		begin
			n = 0;
			do
			begin
				@(posedge core_clk);
				en_at = clk_en;
				#1 clk_en = gap ? ~clk_en : 1'b1;
				if (en_at)
					n++;
			end while (!(en_at && instr_done === 1'b1) && n < 64);
			e.data_pointer = steps[i].dp;
			e.psw = steps[i].fl | {7'h0, ^steps[i].acc};
			e.b = steps[i].b;
			e.acc = steps[i].acc;
			check(40'(n), 40'(steps[i].clks), "clocks");
			check(core_regs, e, "regs");
			check({39'h0, opcode_unknown}, {39'h0, steps[i].unk}, "unknown flag");
			pc_exp = 16'(pc_exp + 16'(steps[i].len));
			check({24'h0, prog_addr}, {24'h0, pc_exp}, "next address");
		end
		$display("Test %s done", name);
		steps.delete();
		gap = 1'b0;
	endtask : run

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_add();
		st(8'h24, 8'h85, 2, 8, 8'h85, 8'h00);
		st(8'h24, 8'h80, 2, 8, 8'h05, 8'h84);
		st(8'h2A, 8'h00, 1, 4, 8'h5A, 8'h00);
		st(8'h25, 8'h40, 2, 8, 8'hD1, 8'h44);
		st(8'h26, 8'h00, 1, 4, 8'hE3, 8'h00);
		st(8'h27, 8'h00, 1, 4, 8'hD3, 8'h80);
		run("add");
	endtask : test_add

	task automatic test_add_carry();
		st(8'h34, 8'hFF, 2, 8, 8'hFF, 8'h00);
		st(8'h34, 8'h01, 2, 8, 8'h00, 8'hC0);
		st(8'h3A, 8'h00, 1, 4, 8'h56, 8'h00);
		st(8'h35, 8'h40, 2, 8, 8'hCD, 8'h04);
		st(8'h36, 8'h00, 1, 4, 8'hDF, 8'h00);
		st(8'h37, 8'h00, 1, 4, 8'hCF, 8'h80);
		run("add with carry");
	endtask : test_add_carry

	task automatic test_sub_borrow();
		st(8'h94, 8'h01, 2, 8, 8'hFF, 8'hC0);
		st(8'h9A, 8'h00, 1, 4, 8'hA9, 8'h00);
		st(8'h95, 8'h40, 2, 8, 8'h32, 8'h04);
		st(8'h96, 8'h00, 1, 4, 8'h20, 8'h00);
		st(8'h97, 8'h00, 1, 4, 8'h30, 8'h80);
		run("subtract");
	endtask : test_sub_borrow

	// Carry is left set so that any flag change by increment or decrement shows up
	task automatic test_incdec();
		st(8'h94, 8'h01, 2, 8, 8'hFF, 8'hC0);
		st(8'h04, 8'h00, 1, 4, 8'h00, 8'hC0);
		st(8'h14, 8'h00, 1, 4, 8'hFF, 8'hC0);
		st(8'h0A, 8'h00, 1, 4, 8'hFF, 8'hC0);
		st(8'h1B, 8'h00, 1, 4, 8'hFF, 8'hC0);
		st(8'h05, 8'h40, 2, 8, 8'hFF, 8'hC0);
		st(8'h15, 8'h41, 2, 8, 8'hFF, 8'hC0);
		st(8'h16, 8'h00, 1, 4, 8'hFF, 8'hC0);
		st(8'h07, 8'h00, 1, 4, 8'hFF, 8'hC0);
		st(8'h5A, 8'h00, 1, 4, 8'h56, 8'hC0);
		st(8'h3B, 8'h00, 1, 4, 8'h56, 8'hC0);
		st(8'h25, 8'h40, 2, 8, 8'hCE, 8'h04);
		st(8'h26, 8'h00, 1, 4, 8'hDF, 8'h00);
		st(8'h27, 8'h00, 1, 4, 8'hD0, 8'hC0);
		st(8'h35, 8'h41, 2, 8, 8'hD0, 8'hC0);
		run("increment decrement");
	endtask : test_incdec

	task automatic test_muldiv();
		st(8'h24, 8'hC8, 2, 8, 8'hC8, 8'h00);
		st(8'h05, 8'hF0, 2, 8, 8'hC8, 8'h00, 8'h01);
		st(8'h05, 8'hF0, 2, 8, 8'hC8, 8'h00, 8'h02);
		st(8'hA4, 8'h00, 1, 20, 8'h90, 8'h04, 8'h01);
		st(8'h84, 8'h00, 1, 20, 8'h90, 8'h00, 8'h00);
		st(8'h84, 8'h00, 1, 20, 8'h90, 8'h04, 8'h00);
		st(8'h15, 8'h82, 2, 8, 8'h90, 8'h04, 8'h00, 16'h00FF);
		st(8'hA3, 8'h00, 1, 12, 8'h90, 8'h04, 8'h00, 16'h0100);
		st(8'h24, 8'h19, 2, 8, 8'hA9, 8'h00, 8'h00, 16'h0100);
		st(8'hD4, 8'h00, 1, 4, 8'h09, 8'h80, 8'h00, 16'h0100);
		run("multiply divide adjust");
	endtask : test_muldiv

	// Direct operands in the special register space, indirect increment and decrement, adjust with aux carry
	task automatic test_direct_sfr();
		st(8'h24, 8'h38, 2, 8, 8'h38, 8'h00);
		st(8'h25, 8'hE0, 2, 8, 8'h70, 8'h40);
		st(8'h06, 8'h00, 1, 4, 8'h70, 8'h40);
		st(8'h17, 8'h00, 1, 4, 8'h70, 8'h40);
		st(8'h26, 8'h00, 1, 4, 8'h83, 8'h04);
		st(8'h27, 8'h00, 1, 4, 8'h72, 8'hC4);
		st(8'hD4, 8'h00, 1, 4, 8'hD8, 8'hC4);
		st(8'h05, 8'hE0, 2, 8, 8'hD9, 8'hC4);
		st(8'h05, 8'h83, 2, 8, 8'hD9, 8'hC4, 8'h00, 16'h0100);
		st(8'h95, 8'hF0, 2, 8, 8'hD8, 8'h00, 8'h00, 16'h0100);
		run("direct special registers");
	endtask : test_direct_sfr

	// Clock enable toggles every cycle: timing is counted in enabled clocks only
	task automatic test_unknown();
		gap = 1'b1;
		st(8'hA5, 8'h00, 1, 4, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b1);
		st(8'h28, 8'h00, 1, 4, 8'h30, 8'h00);
		st(8'h58, 8'h00, 1, 4, 8'h30, 8'h00);
		st(8'hA5, 8'h00, 1, 4, 8'h30, 8'h00, 8'h00, 16'h0000, 1'b1);
		run("unknown opcode");
	endtask : test_unknown

	initial
	begin
		repeat (10) @(posedge core_clk);
		test_add();
		test_add_carry();
		test_sub_borrow();
		test_incdec();
		test_muldiv();
		test_direct_sfr();
		test_unknown();
		end_sim();
	end
endmodule : arith_instruction_decode_tb
